// ==== hw/byte_transfer_operand_decode.sv ====
// The APB interface to the registers and the placing of the registers were left to the implementer.
`include "byte_xfer_map.svh"
`default_nettype none
module byte_transfer_operand_decode (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Execution status
  output logic             busy
);
  import byte_xfer_pkg::*;

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic operand_ok(input operand_kind_t k, input logic [15:0] v);
    case (k)
      K_SADDR:    operand_ok = in_range(v, `SADDR_LO, `SADDR_HI);
      K_SADDRP:   operand_ok = in_range(v, `SADDR_LO, `SADDR_HI) && !v[0];
      K_ABS:      operand_ok = 1'b1;
      K_ABSW:     operand_ok = !v[0];
      K_CALL:     operand_ok = in_range(v, `CALL_LO, `CALL_HI);
      K_TABLE:    operand_ok = in_range(v, `TABLE_LO, `TABLE_HI) && !v[0];
      K_SFR:      operand_ok = (v[15:8] == `SFR_PAGE) && !in_range(v, `SFR_GAP_LO, `SFR_GAP_HI);
      K_SFRP:     operand_ok = (v[15:8] == `SFR_PAGE) && !in_range(v, `SFR_GAP_LO, `SFR_GAP_HI) && !v[0];
      K_IMM_WORD: operand_ok = 1'b1;
      K_IMM_BYTE: operand_ok = (v[15:8] == 8'h00);
      K_IMM_BIT:  operand_ok = (v[15:3] == 13'h0000);
      default:    operand_ok = 1'b0;
    endcase
  endfunction : operand_ok

  function automatic mode_t mode_of(input form_t f);
    case (f)
      F_R_IMM, F_SADDR_IMM, F_SFR_IMM, F_PSW_IMM: mode_of = M_IMM;
      F_A_R, F_R_A, F_A_PSW, F_PSW_A:             mode_of = M_REG;
      F_A_DE, F_DE_A, F_A_HL, F_HL_A, F_A_HLD, F_HLD_A,
      F_A_HLB, F_HLB_A, F_A_HLC, F_HLC_A:         mode_of = M_IND;
      default:                                    mode_of = M_ABS;
    endcase
  endfunction : mode_of

  // Table of cycle pairs; exchange forms other than A,r take the extra read-modify-write
  function automatic logic [7:0] cyc_of(input xfer_op_t op, input form_t f);
    if (op == OP_EXCH) begin
      case (f)
        F_A_R:                       cyc_of = `CYC_REG_REG;
        F_A_SADDR, F_A_DE, F_A_HL:   cyc_of = `CYC_XCH_SHORT;
        F_A_SFR:                     cyc_of = `CYC_XCH_SFR;
        default:                     cyc_of = `CYC_XCH_LONG;
      endcase
    end else begin
      case (f)
        F_A_R, F_R_A:                cyc_of = `CYC_REG_REG;
        F_R_IMM:                     cyc_of = `CYC_REG_IMM;
        F_SADDR_IMM:                 cyc_of = `CYC_MEM_IMM;
        F_SFR_IMM, F_PSW_IMM:        cyc_of = `CYC_SFR_IMM;
        F_A_SFR, F_SFR_A, F_A_PSW, F_PSW_A: cyc_of = `CYC_SFR;
        F_A_ABS, F_ABS_A, F_A_HLD, F_HLD_A: cyc_of = `CYC_LONG;
        F_A_HLB, F_HLB_A, F_A_HLC, F_HLC_A: cyc_of = `CYC_INDEXED;
        default:                     cyc_of = `CYC_SHORT;
      endcase
    end
  endfunction : cyc_of

  function automatic logic flag_apply(input flag_act_t act, input logic cur, input logic calc, input logic saved);
    case (act)
      FA_CLR:     flag_apply = 1'b0;
      FA_SET:     flag_apply = 1'b1;
      FA_CALC:    flag_apply = calc;
      FA_RESTORE: flag_apply = saved;
      default:    flag_apply = cur;
    endcase
  endfunction : flag_apply

  function automatic flag_act_t psw_act(input int b);
    psw_act = (b == `PSW_Z_BIT || b == `PSW_AC_BIT || b == `PSW_CY_BIT) ? FA_CALC : FA_KEEP;
  endfunction : psw_act

  // State
  logic [7:0]  regs_q [0:7];
  logic [7:0]  mem_q  [0:511];
  logic [7:0]  psw_q;
  logic [7:0]  psw_save_q;
  instr_t      instr_q;
  imm_word_t   operand_q;
  state_t      state_q;
  logic [3:0]  cnt_q;
  logic [3:0]  last_cyc_q;
  logic        err_q;
  logic        fast_q;
  logic [19:0] check_q;
  logic [23:0] branch_q;
  logic [15:0] mem_addr_q;
  logic [31:0] prdata_q;

  // Pair view of the byte registers
  logic [15:0] pair_w [0:3];
  for (genvar i = 0; i < 4; i++) begin : g_pair
    assign pair_w[i] = {regs_q[2*i+1], regs_q[2*i]};
  end
  wire [7:0]  acc_w   = regs_q[`ACC_IDX];
  wire [15:0] de_w    = pair_w[2];
  wire [15:0] hl_w    = pair_w[3];

  // Bus decode
  wire        setup_w  = psel && !penable;
  wire        access_w = psel && penable;
  wire        wr_w     = access_w && pwrite;
  wire        hit_ctrl = (paddr == `REG_CTRL);
  wire        hit_opnd = (paddr == `REG_OPERAND);
  wire        hit_stat = (paddr == `REG_STATUS);
  wire        hit_blo  = (paddr == `REG_BYTES_LO);
  wire        hit_bhi  = (paddr == `REG_BYTES_HI);
  wire        hit_psw  = (paddr == `REG_PSW);
  wire        hit_chk  = (paddr == `REG_CHECK);
  wire        hit_br   = (paddr == `REG_BRANCH);
  wire        hit_madr = (paddr == `REG_MEM_ADDR);
  wire        hit_mdat = (paddr == `REG_MEM_DATA);
  wire        hit_plo  = (paddr == `REG_PAIRS_LO);
  wire        hit_phi  = (paddr == `REG_PAIRS_HI);
  wire        mapped_w = hit_ctrl | hit_opnd | hit_stat | hit_blo | hit_bhi | hit_psw | hit_chk | hit_br |
                         hit_madr | hit_mdat | hit_plo | hit_phi;
  wire        idle_w   = (state_q == ST_IDLE);
  // Software may not touch the operand state while an instruction runs
  wire        sw_wr_w  = wr_w && idle_w;
  wire        go_w     = sw_wr_w && hit_ctrl && pwdata[`CTRL_GO_BIT];

  // Operand decode of the latched instruction
  wire form_t     form_w  = instr_q.form;
  wire mode_t     mode_w  = mode_of(form_w);
  wire            exch_w  = (instr_q.op == OP_EXCH);
  wire            sadr_w  = form_w inside {F_SADDR_IMM, F_A_SADDR, F_SADDR_A};
  wire            sfr_w   = form_w inside {F_SFR_IMM, F_A_SFR, F_SFR_A};
  wire            mem_w   = sadr_w || sfr_w || mode_w == M_ABS || mode_w == M_IND;
  wire [15:0]     ea_w    = sfr_w                                 ? {`SFR_PAGE, instr_q.operand[7:0]} :
                            form_w inside {F_A_DE, F_DE_A}        ? de_w :
                            form_w inside {F_A_HL, F_HL_A}        ? hl_w :
                            form_w inside {F_A_HLD, F_HLD_A}      ? 16'(hl_w + {8'h00, instr_q.operand[7:0]}) :
                            form_w inside {F_A_HLB, F_HLB_A}      ? 16'(hl_w + {8'h00, regs_q[3]}) :
                            form_w inside {F_A_HLC, F_HLC_A}      ? 16'(hl_w + {8'h00, regs_q[2]}) :
                            instr_q.operand;
  wire            fast_w  = !mem_w || in_range(ea_w, `SADDR_LO, `SADDR_HI);
  wire [7:0]      cpair_w = cyc_of(instr_q.op, form_w);
  wire [3:0]      cyc_w   = fast_w ? cpair_w[7:4] : cpair_w[3:0];
  wire            xform_w = form_w inside {F_A_R, F_A_SADDR, F_A_SFR, F_A_ABS, F_A_DE, F_A_HL,
                                           F_A_HLD, F_A_HLB, F_A_HLC};
  wire            self_w  = (instr_q.rsel == `ACC_IDX) && (form_w == F_R_A || (exch_w && form_w == F_A_R));
  wire            bad_w   = (form_w > F_HLC_A) || (exch_w && !xform_w) || self_w ||
                            (sadr_w && !operand_ok(K_SADDR, ea_w)) ||
                            (sfr_w && !operand_ok(K_SFR, ea_w)) ||
                            (mem_w && ea_w[15:9] != `MEM_PAGE);
  wire [7:0]      mrd_w   = mem_q[ea_w[8:0]];
  wire [7:0]      rsel_w  = regs_q[instr_q.rsel];
  wire            commit_w = (state_q == ST_EXEC) && (cnt_q == 4'd0);

  // Commit data path
  commit_t cm;
  always_comb begin
    cm = '0;
    if (exch_w) begin
      cm.a_we = 1'b1;
      cm.a_val = (form_w == F_A_R) ? rsel_w : mrd_w;
      cm.r_we = (form_w == F_A_R);
      cm.r_val = acc_w;
      cm.m_we = (form_w != F_A_R);
      cm.m_val = acc_w;
    end else begin
      case (form_w)
        F_R_IMM: begin
          cm.r_we = 1'b1;
          cm.r_val = instr_q.operand[7:0];
        end
        F_SADDR_IMM, F_SFR_IMM: begin
          cm.m_we = 1'b1;
          cm.m_val = instr_q.operand[7:0];
        end
        F_A_R: begin
          cm.a_we = 1'b1;
          cm.a_val = rsel_w;
        end
        F_R_A: begin
          cm.r_we = 1'b1;
          cm.r_val = acc_w;
        end
        F_PSW_IMM: begin
          cm.p_we = 1'b1;
          cm.p_val = instr_q.operand[7:0];
        end
        F_PSW_A: begin
          cm.p_we = 1'b1;
          cm.p_val = acc_w;
        end
        F_A_PSW: begin
          cm.a_we = 1'b1;
          cm.a_val = psw_q;
        end
        F_SADDR_A, F_SFR_A, F_ABS_A, F_DE_A, F_HL_A, F_HLD_A, F_HLB_A, F_HLC_A: begin
          cm.m_we = 1'b1;
          cm.m_val = acc_w;
        end
        default: begin
          cm.a_we = 1'b1;
          cm.a_val = mrd_w;
        end
      endcase
    end
  end

  // Status word update: only the three result flags follow a status move
  logic [7:0] psw_new;
  always_comb begin
    psw_new = psw_q;
    for (int b = 0; b < 8; b++) begin
      psw_new[b] = flag_apply(psw_act(b), psw_q[b], cm.p_val[b], psw_save_q[b]);
    end
  end

  // Checker and branch helpers
  wire operand_kind_t chk_kind_w = operand_kind_t'(check_q[19:16]);
  wire [15:0] br_tgt_w = 16'(branch_q[15:0] + {{8{branch_q[23]}}, branch_q[23:16]});

  // Readback
  wire [31:0] rd_w =
    hit_ctrl ? {23'h00_0000, instr_q.op, instr_q.rsel, instr_q.form} :
    hit_opnd ? {16'h0000, operand_q} :
    hit_stat ? {20'h0_0000, last_cyc_q, 5'h00, fast_q, err_q, busy} :
    hit_blo  ? {regs_q[3], regs_q[2], regs_q[1], regs_q[0]} :
    hit_bhi  ? {regs_q[7], regs_q[6], regs_q[5], regs_q[4]} :
    hit_psw  ? {24'h00_0000, psw_q} :
    hit_chk  ? {operand_ok(chk_kind_w, check_q[15:0]), 11'h000, check_q} :
    hit_br   ? {br_tgt_w, branch_q[23:16], 8'h00} :
    hit_madr ? {16'h0000, mem_addr_q} :
    hit_mdat ? {24'h00_0000, mem_q[mem_addr_q[8:0]]} :
    hit_plo  ? {pair_w[1], pair_w[0]} :
    hit_phi  ? {pair_w[3], pair_w[2]} :
    32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = access_w && !mapped_w;
  assign prdata  = prdata_q;
  assign busy    = !idle_w;

  // Sequencer: CHECK takes one cycle, EXEC the rest, one count per clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 4'h0;
      err_q      <= 1'b0;
      fast_q     <= 1'b0;
      last_cyc_q <= 4'h0;
      psw_save_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go_w) begin
            state_q    <= ST_CHECK;
            err_q      <= 1'b0;
            psw_save_q <= psw_q;
          end
        end
        ST_CHECK: begin
          if (bad_w) begin
            state_q <= ST_IDLE;
            err_q   <= 1'b1;
          end else begin
            state_q    <= ST_EXEC;
            cnt_q      <= 4'(cyc_w - 4'd2);
            fast_q     <= fast_w;
            last_cyc_q <= cyc_w;
          end
        end
        ST_EXEC: begin
          if (cnt_q == 4'd0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= 4'(cnt_q - 4'd1);
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Software-visible registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q    <= '0;
      operand_q  <= 16'h0000;
      check_q    <= 20'h0_0000;
      branch_q   <= 24'h00_0000;
      mem_addr_q <= 16'h0000;
      prdata_q   <= 32'h0000_0000;
      psw_q      <= `PSW_RESET;
    end else begin
      if (setup_w) begin
        prdata_q <= rd_w;
      end
      if (go_w) begin
        instr_q <= {xfer_op_t'(pwdata[`CTRL_OP_BIT]), form_t'(pwdata[`CTRL_FORM_LSB +: 5]),
                    pwdata[`CTRL_REG_LSB +: 3], operand_q};
      end
      if (sw_wr_w && hit_opnd) operand_q <= pwdata[15:0];
      if (wr_w && hit_chk) check_q <= pwdata[19:0];
      if (wr_w && hit_br) branch_q <= pwdata[23:0];
      if (sw_wr_w && hit_madr) mem_addr_q <= pwdata[15:0];
      if (sw_wr_w && hit_psw) psw_q <= pwdata[7:0];
      else if (commit_w && cm.p_we) psw_q <= psw_new;
    end
  end

  // Byte registers; exchange writes both ends in the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) regs_q[i] <= 8'h00;
    end else if (sw_wr_w && (hit_blo || hit_bhi)) begin
      for (int i = 0; i < 4; i++) regs_q[hit_bhi ? i + 4 : i] <= pwdata[8*i +: 8];
    end else if (commit_w) begin
      if (cm.r_we) regs_q[instr_q.rsel] <= cm.r_val;
      if (cm.a_we) regs_q[`ACC_IDX] <= cm.a_val;
    end
  end

  // Data memory: no reset, contents are software's
  always_ff @(posedge pclk) begin
    if (sw_wr_w && hit_mdat) begin
      mem_q[mem_addr_q[8:0]] <= pwdata[7:0];
    end else if (commit_w && cm.m_we) begin
      mem_q[ea_w[8:0]] <= cm.m_val;
    end
  end

endmodule : byte_transfer_operand_decode
`default_nettype wire

// ==== include/byte_xfer_map.svh ====
// What this block does
// - Byte registers 0..7 are X,A,C,B,E,D,L,H
// - Pairs 0..3 are AX,BC,DE,HL
// - Short direct reaches FE20H-FF1FH only; word even
// - Absolute operand check accepts all, but execution reaches FE00H-FFFFH only; word form even
// - Call target confined to 0800H-0FFFH
// - Table address even within 0040H-007FH
// - Special-register forms cannot reach FFD0H-FFDFH
// - Special-register word operand: even, word-capable only
// - Immediates decode as word, byte, bit position
// - Five modes: register, immediate, absolute, relative, indirect
// - Flags kept, cleared, set, computed or restored
// - A is byte accumulator, AX word accumulator
// - Register pairs split into upper, lower halves
// - Branch displacement signed 8-bit, added to PC
// - First count for fast RAM, else second
// - One counted cycle is one clock period
`ifndef BYTE_XFER_MAP_SVH
`define BYTE_XFER_MAP_SVH

// Register offsets
`define REG_CTRL     12'h000
`define REG_OPERAND  12'h004
`define REG_STATUS   12'h008
`define REG_BYTES_LO 12'h00C
`define REG_BYTES_HI 12'h010
`define REG_PSW      12'h014
`define REG_CHECK    12'h018
`define REG_BRANCH   12'h01C
`define REG_MEM_ADDR 12'h020
`define REG_MEM_DATA 12'h024
`define REG_PAIRS_LO 12'h028
`define REG_PAIRS_HI 12'h02C

// Control fields
`define CTRL_FORM_LSB 0
`define CTRL_REG_LSB  5
`define CTRL_OP_BIT   8
`define CTRL_GO_BIT   31
`define CHECK_KIND_LSB 16
`define BRANCH_DISP_LSB 16

// Status word bit positions
`define PSW_CY_BIT 0
`define PSW_AC_BIT 4
`define PSW_Z_BIT  6
`define PSW_RESET  8'h02

// Address windows
`define SADDR_LO   16'hFE20
`define SADDR_HI   16'hFF1F
`define SFR_PAGE   8'hFF
`define SFR_GAP_LO 16'hFFD0
`define SFR_GAP_HI 16'hFFDF
`define CALL_LO    16'h0800
`define CALL_HI    16'h0FFF
`define TABLE_LO   16'h0040
`define TABLE_HI   16'h007F
`define MEM_PAGE   7'h7F
`define ACC_IDX    3'd1

// Cycle counts: upper nibble fast RAM or no access, lower nibble other areas
`define CYC_REG_REG   8'h22
`define CYC_REG_IMM   8'h44
`define CYC_MEM_IMM   8'h67
`define CYC_SFR_IMM   8'h77
`define CYC_SHORT     8'h45
`define CYC_SFR       8'h55
`define CYC_LONG      8'h89
`define CYC_INDEXED   8'h67
`define CYC_XCH_SHORT 8'h46
`define CYC_XCH_SFR   8'h66
`define CYC_XCH_LONG  8'h8A

`endif

// ==== include/byte_xfer_pkg.sv ====
`default_nettype none
package byte_xfer_pkg;
  typedef enum logic {OP_MOVE, OP_EXCH} xfer_op_t;
  typedef enum logic [4:0] {
    F_R_IMM, F_SADDR_IMM, F_SFR_IMM, F_A_R, F_R_A, F_A_SADDR, F_SADDR_A, F_A_SFR,
    F_SFR_A, F_A_ABS, F_ABS_A, F_PSW_IMM, F_A_PSW, F_PSW_A, F_A_DE, F_DE_A,
    F_A_HL, F_HL_A, F_A_HLD, F_HLD_A, F_A_HLB, F_HLB_A, F_A_HLC, F_HLC_A
  } form_t;
  typedef enum logic [2:0] {M_REG, M_IMM, M_ABS, M_REL, M_IND} mode_t;
  typedef enum logic [3:0] {
    K_SADDR, K_SADDRP, K_ABS, K_ABSW, K_CALL, K_TABLE, K_SFR, K_SFRP,
    K_IMM_WORD, K_IMM_BYTE, K_IMM_BIT
  } operand_kind_t;
  typedef enum logic [2:0] {FA_KEEP, FA_CLR, FA_SET, FA_CALC, FA_RESTORE} flag_act_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_EXEC} state_t;
  typedef logic [15:0] imm_word_t;
  typedef logic [7:0]  imm_byte_t;
  typedef logic [2:0]  imm_bit_t;
  typedef struct packed {
    xfer_op_t  op;
    form_t     form;
    logic [2:0] rsel;
    imm_word_t operand;
  } instr_t;
  typedef struct packed {
    logic       a_we;
    imm_byte_t  a_val;
    logic       r_we;
    imm_byte_t  r_val;
    logic       m_we;
    imm_byte_t  m_val;
    logic       p_we;
    imm_byte_t  p_val;
  } commit_t;
endpackage : byte_xfer_pkg
`default_nettype wire

// ==== verification/byte_transfer_operand_decode_checker.sv ====
`default_nettype none
module byte_transfer_operand_decode_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Execution status
  input wire logic        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire mapped_w = (paddr <= 12'h02C) && (paddr[1:0] == 2'b00);
  wire access_w = psel && penable;
  wire setup_w  = psel && !penable;
  wire go_req_w = access_w && pwrite && (paddr == 12'h000) && pwdata[31];

  // A start request only counts while idle
  sequence go_idle_s;
    go_req_w && !busy;
  endsequence
  sequence busy_start_s;
    !busy ##1 busy;
  endsequence

  AST_PREADY: assert property (access_w |-> pready)
    else $error("pready low in access phase");
  AST_ERR_PHASE: assert property (pslverr |-> access_w)
    else $error("pslverr outside access phase");
  AST_ERR_UNMAPPED: assert property (access_w && (paddr > 12'h02C) |-> pslverr)
    else $error("unmapped access not flagged");
  AST_ERR_MAPPED: assert property (access_w && mapped_w |-> !pslverr)
    else $error("mapped access flagged");
  AST_GO_START: assert property (go_idle_s |=> busy)
    else $error("busy did not rise after start");
  AST_BUSY_CAUSE: assert property (busy_start_s |-> $past(go_req_w))
    else $error("busy rose without start");
  AST_BUSY_BOUND: assert property (busy_start_s |-> ##[1:10] !busy)
    else $error("busy longer than longest count");
  AST_PRDATA_HOLD: assert property (!$stable(prdata) |-> $past(setup_w))
    else $error("read data changed outside setup");
endmodule : byte_transfer_operand_decode_checker

bind byte_transfer_operand_decode byte_transfer_operand_decode_checker i_byte_transfer_operand_decode_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy)
);
`default_nettype wire

// ==== verification/tb_byte_transfer_operand_decode.sv ====
`include "byte_xfer_map.svh"
`default_nettype none
module tb_byte_transfer_operand_decode import byte_xfer_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, st;
  int          error_cnt, samples_checked;
  // Valid flag in bit 31, kind and value below
  logic [31:0] ck [30] = '{32'h8000_FE20, 32'h0000_FE1F, 32'h8000_FF1F, 32'h0000_FF20, 32'h0001_FE21,
    32'h8001_FE22, 32'h8002_0000, 32'h8002_FFFF, 32'h0003_0001, 32'h8003_FFFE, 32'h0004_07FF,
    32'h8004_0800, 32'h8004_0FFF, 32'h0004_1000, 32'h8005_0040, 32'h0005_0041, 32'h8005_007E,
    32'h0005_0080, 32'h8006_FFCF, 32'h0006_FFD0, 32'h0006_FFDF, 32'h0006_FE00, 32'h0007_FFE1,
    32'h8007_FFE0, 32'h8008_FFFF, 32'h8009_00FF, 32'h0009_0100, 32'h800A_0007, 32'h000A_0008,
    32'h000B_0000};

  always #2.5 pclk = ~pclk;

  byte_transfer_operand_decode i_byte_transfer_operand_decode (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

  // Waits for pready with no limit of its own; only the watchdog ends a stuck wait
  task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb_xfer(1'b0, a, 32'h0000_0000);
    chk32(nm, e, rdat & m);
  endtask : rd_chk

  // Polls status; the bench never assumes an execution length
  task automatic run_instr(input logic op, input form_t f, input logic [2:0] r, input logic [15:0] v);
    apb_xfer(1'b1, `REG_OPERAND, {16'h0000, v});
    apb_xfer(1'b1, `REG_CTRL, {1'b1, 22'h00_0000, op, r, f});
    do begin
      apb_xfer(1'b0, `REG_STATUS, 32'h0000_0000);
    end while (rdat[0] !== 1'b0);
    st = rdat;
  endtask : run_instr

  task automatic mem_wr(input logic [15:0] a, input logic [7:0] d);
    apb_xfer(1'b1, `REG_MEM_ADDR, {16'h0000, a});
    apb_xfer(1'b1, `REG_MEM_DATA, {24'h00_0000, d});
  endtask : mem_wr

  task automatic br_chk(input logic [15:0] pc, input logic [7:0] disp, input logic [15:0] e);
    apb_xfer(1'b1, `REG_BRANCH, {8'h00, disp, pc});
    rd_chk("branch target", `REG_BRANCH, 32'hFFFF_FF00, {e, disp, 8'h00});
  endtask : br_chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    $display("ERROR watchdog expected done seen hang");
    tally_and_finish();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite} = 5'b0_0000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    error_cnt = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("psw reset", `REG_PSW, 32'h0000_00FF, 32'h0000_0002);
    rd_chk("status reset", `REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    apb_xfer(1'b0, 12'h030, 32'h0000_0000);
    chk32("unmapped err", 32'h1, {31'h0, rerr});
    chk32("unmapped data", 32'h0, rdat);
    $display("test reset done");
    // Distinct byte per register so any renumbering shows
    apb_xfer(1'b1, `REG_BYTES_LO, 32'h1312_1110);
    apb_xfer(1'b1, `REG_BYTES_HI, 32'h1716_1514);
    rd_chk("pairs lo", `REG_PAIRS_LO, 32'hFFFF_FFFF, 32'h1312_1110);
    rd_chk("pairs hi", `REG_PAIRS_HI, 32'hFFFF_FFFF, 32'h1716_1514);
    for (int r = 0; r < 8; r++) begin
      apb_xfer(1'b1, `REG_BYTES_LO, 32'h1312_1110);
      run_instr(1'b0, F_A_R, r[2:0], 16'h0000);
      chk32("move count", 32'h2, {28'h000_0000, st[11:8]});
      rd_chk("acc after move", `REG_BYTES_LO, 32'h0000_FF00, (32'h0000_0010 + 32'(r)) << 8);
    end
    rd_chk("psw after moves", `REG_PSW, 32'h0000_00FF, 32'h0000_0002);
    $display("test numbering done");
    apb_xfer(1'b1, `REG_BYTES_LO, 32'h1312_1110);
    run_instr(1'b1, F_A_R, 3'd7, 16'h0000);
    rd_chk("exch reg", `REG_BYTES_HI, 32'hFF00_0000, 32'h1100_0000);
    rd_chk("exch acc", `REG_BYTES_LO, 32'h0000_FF00, 32'h0000_1700);
    run_instr(1'b1, F_A_R, 3'd1, 16'h0000);
    chk32("exch acc err", 32'h1, {31'h0, st[1]});
    run_instr(1'b1, F_R_A, 3'd2, 16'h0000);
    chk32("exch form err", 32'h1, {31'h0, st[1]});
    rd_chk("psw after exch", `REG_PSW, 32'h0000_00FF, 32'h0000_0002);
    $display("test exchange done");
    run_instr(1'b0, F_R_IMM, 3'd4, 16'h00A7);
    chk32("imm count", 32'h4, {28'h000_0000, st[11:8]});
    rd_chk("imm byte", `REG_BYTES_HI, 32'h0000_00FF, 32'h0000_00A7);
    run_instr(1'b0, F_SADDR_A, 3'd0, 16'hFF1F);
    chk32("saddr count", 32'h4, {28'h000_0000, st[11:8]});
    apb_xfer(1'b1, `REG_MEM_ADDR, 32'h0000_FF1F);
    rd_chk("saddr store", `REG_MEM_DATA, 32'h0000_00FF, 32'h0000_0017);
    run_instr(1'b0, F_SADDR_A, 3'd0, 16'hFF20);
    chk32("saddr high err", 32'h1, {31'h0, st[1]});
    run_instr(1'b0, F_SADDR_A, 3'd0, 16'hFE1F);
    chk32("saddr low err", 32'h1, {31'h0, st[1]});
    mem_wr(16'hFE00, 8'hA5);
    run_instr(1'b0, F_A_ABS, 3'd0, 16'hFE00);
    chk32("abs count", 32'h9, {28'h000_0000, st[11:8]});
    chk32("abs fast", 32'h0, {31'h0, st[2]});
    rd_chk("abs load", `REG_BYTES_LO, 32'h0000_FF00, 32'h0000_A500);
    mem_wr(16'hFE00, 8'h3C);
    apb_xfer(1'b1, `REG_BYTES_HI, 32'hFE00_15A7);
    run_instr(1'b0, F_A_HL, 3'd0, 16'h0000);
    chk32("ind count", 32'h5, {28'h000_0000, st[11:8]});
    rd_chk("ind load", `REG_BYTES_LO, 32'h0000_FF00, 32'h0000_3C00);
    for (int i = 0; i < 4; i++) begin
      run_instr(1'b0, F_SFR_A, 3'd0, {8'h00, 8'hCF + 8'(i % 2 == 0 ? (i * 8) : (i * 8 - 7))});
      chk32("sfr gap err", {31'h0, i == 1 || i == 2}, {31'h0, st[1]});
    end
    // Accumulator holds 3C, the short direct byte at FF1F holds 17
    run_instr(1'b1, F_A_SADDR, 3'd0, 16'hFF1F);
    chk32("exch saddr count", 32'h4, {28'h000_0000, st[11:8]});
    rd_chk("exch saddr acc", `REG_BYTES_LO, 32'h0000_FF00, 32'h0000_1700);
    apb_xfer(1'b1, `REG_MEM_ADDR, 32'h0000_FF1F);
    rd_chk("exch saddr mem", `REG_MEM_DATA, 32'h0000_00FF, 32'h0000_003C);
    $display("test memory done");
    run_instr(1'b0, F_PSW_A, 3'd0, 16'h0000);
    rd_chk("psw from acc", `REG_PSW, 32'h0000_00FF, 32'h0000_0013);
    run_instr(1'b0, F_A_PSW, 3'd0, 16'h0000);
    rd_chk("acc from psw", `REG_BYTES_LO, 32'h0000_FF00, 32'h0000_1300);
    run_instr(1'b0, F_PSW_IMM, 3'd0, 16'h00FF);
    rd_chk("psw set", `REG_PSW, 32'h0000_00FF, 32'h0000_0053);
    run_instr(1'b0, F_PSW_IMM, 3'd0, 16'h0000);
    rd_chk("psw clear", `REG_PSW, 32'h0000_00FF, 32'h0000_0002);
    $display("test status word done");
    foreach (ck[i]) begin
      apb_xfer(1'b1, `REG_CHECK, ck[i] & 32'h000F_FFFF);
      rd_chk("operand check", `REG_CHECK, 32'h800F_FFFF, ck[i]);
    end
    br_chk(16'h1000, 8'h80, 16'h0F80);
    br_chk(16'hFFF0, 8'h20, 16'h0010);
    br_chk(16'h0100, 8'h7F, 16'h017F);
    $display("test operand ranges done");
    tally_and_finish();
  end
endmodule : tb_byte_transfer_operand_decode
`default_nettype wire
